// ---- core/eid_pkg.sv ----
// constants shared by the expansion identification memory and its array
package eid_pkg;

  // ==========================================================================
  // array geometry
  localparam int eid_mem_depth = 32768;
  localparam int eid_addr_w = 15;
  localparam int eid_data_w = 8;
  localparam int eid_page_bytes = 64;
  localparam int eid_page_w = 6;

  // ==========================================================================
  // bus addressing: 7-bit address 1010_1xx, straps give the two low bits
  localparam logic [3:0] eid_dev_prefix = 4'ha;
  localparam logic chip_address_bit_two = 1'b1;
  localparam logic [6:0] eid_dev_lo = 7'h54;
  localparam logic [6:0] eid_dev_hi = 7'h57;

  // ==========================================================================
  // record layout and fixed content
  localparam logic [7:0] eid_sig_0 = 8'haa;
  localparam logic [7:0] eid_sig_1 = 8'h55;
  localparam logic [7:0] eid_sig_2 = 8'h33;
  localparam logic [7:0] eid_sig_3 = 8'hee;
  localparam int eid_ofs_sig = 0;
  localparam int eid_ofs_rev = 4;
  localparam logic [7:0] eid_rev_0 = 8'h41;
  localparam logic [7:0] eid_rev_1 = 8'h31;
  localparam int eid_ofs_name = 6;
  localparam int eid_len_name = 32;
  localparam int eid_ofs_ver = 38;
  localparam int eid_len_ver = 4;
  localparam int eid_ofs_maker = 42;
  localparam int eid_len_maker = 16;
  localparam int eid_ofs_part = 58;
  localparam int eid_len_part = 16;
  localparam logic [7:0] eid_blank = 8'hff;

  // ==========================================================================
  // bus states and reset values
  typedef enum logic [2:0] {st_idle, st_dev, st_ahi, st_alo, st_wr, st_rd} eid_state_t;
  // strap 00, write protected, bus idle high: no false edge and no unguarded write
  localparam logic [4:0] eid_pins_rst = 5'h07;

endpackage

// ---- core/eid_mem.sv ----
// one-write one-read byte memory with registered read data
`timescale 1ns/1ps
module eid_mem
  import eid_pkg::*;
#(
  parameter int width = 8,
  parameter int depth = 64,
  parameter int aw = 6,
  parameter bit init_record = 1'b0,
  parameter logic [8*eid_len_name-1:0] name_text = "expansion board",
  parameter logic [8*eid_len_ver-1:0] version_text = "0001",
  parameter logic [8*eid_len_maker-1:0] maker_text = "board maker",
  parameter logic [8*eid_len_part-1:0] part_text = "part number"
) (
  // clock
  input wire logic clk,
  // write port
  input wire logic we,
  input wire logic [aw-1:0] waddr,
  input wire logic [width-1:0] wdata,
  // read port
  input wire logic [aw-1:0] raddr,
  output logic [width-1:0] rdata
);

  logic [width-1:0] mem [depth];

  // ==========================================================================
  // power-on content: blank array, then the identification record
  initial begin
    for (int i = 0; i < depth; i++) begin
      mem[i] = width'(eid_blank);
    end
    if (init_record) begin
      mem[eid_ofs_sig] = width'(eid_sig_0);
      mem[eid_ofs_sig + 1] = width'(eid_sig_1);
      mem[eid_ofs_sig + 2] = width'(eid_sig_2);
      mem[eid_ofs_sig + 3] = width'(eid_sig_3);
      mem[eid_ofs_rev] = width'(eid_rev_0);
      mem[eid_ofs_rev + 1] = width'(eid_rev_1);
      // text fields stored first character at lowest offset
      for (int i = 0; i < eid_len_name; i++) begin
        mem[eid_ofs_name + i] = width'(name_text[8*(eid_len_name-1-i) +: 8]);
      end
      for (int i = 0; i < eid_len_ver; i++) begin
        mem[eid_ofs_ver + i] = width'(version_text[8*(eid_len_ver-1-i) +: 8]);
      end
      for (int i = 0; i < eid_len_maker; i++) begin
        mem[eid_ofs_maker + i] = width'(maker_text[8*(eid_len_maker-1-i) +: 8]);
      end
      for (int i = 0; i < eid_len_part; i++) begin
        mem[eid_ofs_part + i] = width'(part_text[8*(eid_len_part-1-i) +: 8]);
      end
    end
  end

  // ==========================================================================
  // no reset here: contents are nonvolatile
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule // eid_mem

// ---- core/eid_eeprom.sv ----
// serial identification memory for an expansion board, bus slave and array
`timescale 1ns/1ps
module eid_eeprom
  import eid_pkg::*;
#(
  parameter logic [8*eid_len_name-1:0] name_text = "expansion board",
  parameter logic [8*eid_len_ver-1:0] version_text = "0001",
  parameter logic [8*eid_len_maker-1:0] maker_text = "board maker",
  parameter logic [8*eid_len_part-1:0] part_text = "part number"
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // expansion_id_bus pins, sda is open drain
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // board straps and write protect
  input wire logic [1:0] addr_strap,
  input wire logic wp,
  // status
  output logic write_busy
);

  // ==========================================================================
  // pin synchronisers: three stages, a change counts once stages two and three agree
  logic [4:0] sy1, sy2, sy3, pins, pins_prev;
  logic [4:0] next_pins;

  always_comb begin
    next_pins = pins;
    for (int i = 0; i < 5; i++) begin
      if (sy2[i] == sy3[i]) next_pins[i] = sy3[i];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sy1 <= eid_pins_rst;
      sy2 <= eid_pins_rst;
      sy3 <= eid_pins_rst;
      pins <= eid_pins_rst;
      pins_prev <= eid_pins_rst;
    end else begin
      sy1 <= {addr_strap, wp, sda_in, scl_in};
      sy2 <= sy1;
      sy3 <= sy2;
      pins <= next_pins;
      pins_prev <= pins;
    end
  end

  // filtered levels and bus events; 40 clocks per bit at 1 MHz leaves ample margin
  logic scl_f, sda_f, wp_f, scl_rise, scl_fall, start_ev, stop_ev;
  logic [6:0] dev_addr;
  assign scl_f = pins[0];
  assign sda_f = pins[1];
  assign wp_f = pins[2];
  assign scl_rise = scl_f & ~pins_prev[0];
  assign scl_fall = ~scl_f & pins_prev[0];
  assign start_ev = scl_f & pins_prev[0] & pins_prev[1] & ~sda_f;
  assign stop_ev = scl_f & pins_prev[0] & ~pins_prev[1] & sda_f;
  assign dev_addr = {eid_dev_prefix, chip_address_bit_two, pins[4:3]};

  // ==========================================================================
  // bus state
  eid_state_t st, next_st;
  logic [3:0] bitcnt, next_bitcnt;
  logic ack_ph, next_ack_ph, rd_more, next_rd_more, next_sda_oe;
  logic [7:0] sh, next_sh;
  logic [eid_addr_w-1:0] ptr, next_ptr;
  logic [eid_page_w-1:0] wstart, next_wstart, wofs, next_wofs;
  logic [eid_page_w:0] wcnt, next_wcnt;
  logic [eid_addr_w-eid_page_w-1:0] wpage, next_wpage;
  logic buf_we, commit_go, busy;
  logic [eid_page_w-1:0] buf_waddr, buf_raddr;
  logic [7:0] buf_wdata, buf_rdata, mem_rdata;

  // one step per filtered bus event; stop outranks start outranks clock edges
  always_comb begin
    next_st = st;
    next_bitcnt = bitcnt;
    next_ack_ph = ack_ph;
    next_rd_more = rd_more;
    next_sda_oe = sda_oe;
    next_sh = sh;
    next_ptr = ptr;
    next_wstart = wstart;
    next_wofs = wofs;
    next_wcnt = wcnt;
    next_wpage = wpage;
    buf_we = 1'b0;
    buf_waddr = wofs;
    buf_wdata = sh;
    commit_go = 1'b0;
    if (stop_ev) begin
      commit_go = (st == st_wr) && (wcnt != '0);
      next_st = st_idle;
      next_ack_ph = 1'b0;
      next_sda_oe = 1'b0;
    end else if (start_ev) begin
      next_st = st_dev;
      next_bitcnt = '0;
      next_ack_ph = 1'b0;
      next_sda_oe = 1'b0;
    end else if (st != st_idle && scl_rise) begin
      if (ack_ph) begin
        // host acknowledge keeps a read going, a not-acknowledge ends it
        if (st == st_rd) begin
          next_rd_more = ~sda_f;
          if (sda_f) next_st = st_idle;
        end
      end else begin
        next_bitcnt = bitcnt + 4'h1;
        next_sh = (st == st_rd) ? {sh[6:0], 1'b0} : {sh[6:0], sda_f};
      end
    end else if (st != st_idle && scl_fall) begin
      if (ack_ph) begin
        next_ack_ph = 1'b0;
        next_bitcnt = '0;
        next_sda_oe = 1'b0;
        if (st == st_rd && rd_more) begin
          // data was prefetched from ptr, so next byte is ready by the next load
          next_sh = mem_rdata;
          next_ptr = ptr + 15'h1;
          next_sda_oe = ~mem_rdata[7];
        end
      end else if (bitcnt == 4'h8) begin
        next_ack_ph = 1'b1;
        case (st)
          st_dev: begin
            // busy committing a page: stay silent like a real part
            if (sh[7:1] == dev_addr && !busy) begin
              next_sda_oe = 1'b1;
              next_rd_more = 1'b1;
              next_st = sh[0] ? st_rd : st_ahi;
            end else begin
              next_st = st_idle;
            end
          end
          st_ahi: begin
            next_sda_oe = 1'b1;
            next_ptr = {sh[6:0], ptr[7:0]};
            next_st = st_alo;
          end
          st_alo: begin
            next_sda_oe = 1'b1;
            next_ptr = {ptr[14:8], sh};
            next_wstart = sh[5:0];
            next_wofs = sh[5:0];
            next_wpage = {ptr[14:8], sh[7:6]};
            next_wcnt = '0;
            next_st = st_wr;
          end
          st_wr: begin
            if (!wp_f) begin
              next_sda_oe = 1'b1;
              buf_we = 1'b1;
              next_wofs = wofs + 6'h1;
              next_ptr = {wpage, wofs + 6'h1};
              if (wcnt != 7'(eid_page_bytes)) next_wcnt = wcnt + 7'h1;
            end
          end
          st_rd: next_sda_oe = 1'b0;
          default: next_st = st_idle;
        endcase
      end else if (st == st_rd) begin
        next_sda_oe = ~sh[7];
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= st_idle;
      bitcnt <= '0;
      ack_ph <= 1'b0;
      rd_more <= 1'b0;
      sda_oe <= 1'b0;
      sda_out <= 1'b0;
      sh <= '0;
      ptr <= '0;
      wstart <= '0;
      wofs <= '0;
      wcnt <= '0;
      wpage <= '0;
    end else begin
      st <= next_st;
      bitcnt <= next_bitcnt;
      ack_ph <= next_ack_ph;
      rd_more <= next_rd_more;
      sda_oe <= next_sda_oe;
      sda_out <= 1'b0;
      sh <= next_sh;
      ptr <= next_ptr;
      wstart <= next_wstart;
      wofs <= next_wofs;
      wcnt <= next_wcnt;
      wpage <= next_wpage;
    end
  end

  // ==========================================================================
  // page commit: two clocks per byte, buffer read then array write
  logic next_busy, cphase, next_cphase, arr_we;
  logic [eid_page_w:0] cidx, next_cidx;
  logic [eid_addr_w-1:0] arr_waddr;

  always_comb begin
    next_busy = busy;
    next_cphase = cphase;
    next_cidx = cidx;
    arr_we = 1'b0;
    if (!busy) begin
      if (commit_go) begin
        next_busy = 1'b1;
        next_cidx = '0;
        next_cphase = 1'b0;
      end
    end else if (!cphase) begin
      next_cphase = 1'b1;
    end else begin
      arr_we = 1'b1;
      next_cphase = 1'b0;
      next_cidx = cidx + 7'h1;
      if (cidx + 7'h1 == wcnt) next_busy = 1'b0;
    end
  end

  assign buf_raddr = wstart + cidx[eid_page_w-1:0];
  assign arr_waddr = {wpage, buf_raddr};

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      busy <= 1'b0;
      cphase <= 1'b0;
      cidx <= '0;
      write_busy <= 1'b0;
    end else begin
      busy <= next_busy;
      cphase <= next_cphase;
      cidx <= next_cidx;
      write_busy <= next_busy;
    end
  end

  // ==========================================================================
  // page buffer and main array (record content preloaded)
  eid_mem #(.width(8), .depth(eid_page_bytes), .aw(eid_page_w)) u_page_buf (
    .clk(clk), .we(buf_we), .waddr(buf_waddr), .wdata(buf_wdata),
    .raddr(buf_raddr), .rdata(buf_rdata)
  );

  eid_mem #(
    .width(eid_data_w), .depth(eid_mem_depth), .aw(eid_addr_w), .init_record(1'b1),
    .name_text(name_text), .version_text(version_text),
    .maker_text(maker_text), .part_text(part_text)
  ) u_array (
    .clk(clk), .we(arr_we), .waddr(arr_waddr), .wdata(buf_rdata),
    .raddr(ptr), .rdata(mem_rdata)
  );

  // ==========================================================================
  // checks
  logic dev_done;
  assign dev_done = (st == st_dev) && scl_fall && !ack_ph && (bitcnt == 4'h8) && !stop_ev
                    && !start_ev;

  chk_dev_range: assert property (@(posedge clk) disable iff (!arst_n)
    dev_done && (sh[7:1] < eid_dev_lo || sh[7:1] > eid_dev_hi) |=> !sda_oe && st == st_idle)
    else $error("answered outside device address range");
  chk_strap_addr: assert property (@(posedge clk) disable iff (!arst_n)
    dev_done && !busy && sh[7:1] == (eid_dev_lo | {5'h0, pins[4:3]}) |=> sda_oe && ack_ph)
    else $error("strapped address not acknowledged");
  chk_addr_order: assert property (@(posedge clk) disable iff (!arst_n)
    (st == st_wr) && ($past(st) != st_wr) |-> $past(st) == st_alo && $past(st, 2) != st_dev)
    else $error("write entered without two address bytes");
  chk_busy_nack: assert property (@(posedge clk) disable iff (!arst_n)
    dev_done && busy |=> !sda_oe)
    else $error("acknowledged while committing a page");
  chk_commit_len: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(busy) |-> ##[2:130] !busy)
    else $error("page commit did not finish in time");
  chk_wp_block: assert property (@(posedge clk) disable iff (!arst_n)
    wp_f && !busy |=> !arr_we && !$past(buf_we))
    else $error("write taken while protected");
  chk_page_wrap: assert property (@(posedge clk) disable iff (!arst_n)
    arr_we |-> arr_waddr[14:6] == ptr[14:6] && (cidx < wcnt))
    else $error("commit left the current page");
  chk_read_incr: assert property (@(posedge clk) disable iff (!arst_n)
    st == st_rd && scl_fall && ack_ph && rd_more && !stop_ev && !start_ev
    |=> ptr == $past(ptr) + 15'h1 && sh == $past(mem_rdata))
    else $error("sequential read did not advance");

  cov_commit: cover property (@(posedge clk) disable iff (!arst_n) $fell(busy));
  cov_seq_read: cover property (@(posedge clk) disable iff (!arst_n)
    st == st_rd && scl_rise && ack_ph && !sda_f);
  cov_wp_nack: cover property (@(posedge clk) disable iff (!arst_n)
    st == st_wr && scl_fall && bitcnt == 4'h8 && !ack_ph && wp_f);

endmodule // eid_eeprom

// ---- sim/eid_host.sv ----
// host bus controller model for the expansion identification bus
`timescale 1ns/1ps
module eid_host (
  // clock
  input wire logic clk,
  // bus pins: scl pushed, sda pulled low only
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  // half period of the bus clock in system clocks, 20 is the fastest rate
  int half = 20;

  // ==========================================================================
  // bit level
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // every change lands 1 ns after a clock edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // start, also used as repeated start from scl low
  task automatic start_cond();
    sda_low = 1'b0;
    tick(half / 2);
    scl = 1'b1;
    tick(half);
    sda_low = 1'b1;
    tick(half);
    scl = 1'b0;
    tick(half / 2);
  endtask

  task automatic stop_cond();
    sda_low = 1'b1;
    tick(half / 2);
    scl = 1'b1;
    tick(half);
    sda_low = 1'b0;
    tick(half);
  endtask

  // one clock pulse, sda sampled mid high where the device holds it
  task automatic pulse(output logic bit_in);
    tick(half / 2);
    scl = 1'b1;
    tick(half / 2);
    bit_in = sda;
    tick(half / 2);
    scl = 1'b0;
    tick(half / 2);
  endtask

  // ==========================================================================
  // byte level, most significant bit first
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      sda_low = ~b[i];
      pulse(s);
    end
    sda_low = 1'b0;
    pulse(s);
    ack = ~s;
  endtask

  // one byte per location; more pulls low to ask for the next one
  task automatic get_byte(input logic more, output logic [7:0] b);
    logic s;
    sda_low = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      pulse(s);
      b[i] = s;
    end
    sda_low = more;
    pulse(s);
  endtask

  // device address with write, then the word address high byte first
  task automatic addr_phase(input logic [6:0] dev, input logic [15:0] wa, output logic ok);
    logic a0;
    logic a1;
    logic a2;
    start_cond();
    send_byte({dev, 1'b0}, a0);
    send_byte(wa[15:8], a1);
    send_byte(wa[7:0], a2);
    ok = a0 & a1 & a2;
  endtask
endmodule // eid_host

// ---- sim/expansion_id_eeprom_tb.sv ----
// self-checking bench for the expansion identification memory
`timescale 1ns/1ps
module expansion_id_eeprom_tb
  import eid_pkg::*;
;
  // ==========================================================================
  // signals and instances
  typedef struct {logic [15:0] wa; logic [7:0] exp; logic [1:0] strap; int half;} eid_row_t;
  logic clk = 1'b0;
  logic arst_n;
  logic scl;
  logic sda_low;
  logic sda;
  logic sda_out;
  logic sda_oe;
  logic [1:0] addr_strap;
  logic wp;
  logic write_busy;
  logic ok;
  logic [7:0] got [$];
  logic [7:0] wdat [$];
  int errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  // addresses that must stay unanswered with strap 00
  logic [6:0] foreign [5] = '{7'h50, 7'h55, 7'h57, 7'h2c, 7'h14};
  // name begins and ends with different letters, so byte order shows
  eid_row_t rows [10] = '{
    '{16'h0000, eid_sig_0, 2'h0, 20}, '{16'h0003, eid_sig_3, 2'h1, 50},
    '{16'h0004, eid_rev_0, 2'h2, 200}, '{16'h0005, eid_rev_1, 2'h3, 20},
    '{16'h0006, 8'h4e, 2'h0, 20}, '{16'h0025, 8'h5a, 2'h1, 20},
    '{16'h0026, 8'h32, 2'h2, 20}, '{16'h002a, 8'h4d, 2'h3, 20},
    '{16'h003a, 8'h50, 2'h0, 20}, '{16'h8049, 8'h50, 2'h1, 20}};

  // pull-up on sda: low when anyone pulls
  assign sda = (sda_low | sda_oe) ? 1'b0 : 1'b1;
  always #12.5 clk = ~clk;

  eid_eeprom #(.name_text({8'h4e, {30{8'h6e}}, 8'h5a}), .version_text({4{8'h32}}),
    .maker_text({16{8'h4d}}), .part_text({16{8'h50}})) dut_u (.clk(clk), .arst_n(arst_n),
    .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .addr_strap(addr_strap), .wp(wp), .write_busy(write_busy));
  eid_host host_u (.clk(clk), .scl(scl), .sda_low(sda_low), .sda(sda));

  // ==========================================================================
  // tasks
  task automatic check(input logic [15:0] got_v, input logic [15:0] exp_v);
    samples_checked++;
    if (got_v !== exp_v) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got_v, exp_v);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // random read of n bytes, last one refused by the host
  task automatic read_bytes(input logic [6:0] dev, input logic [15:0] wa, input int n);
    logic a;
    logic [7:0] b;
    host_u.addr_phase(dev, wa, ok);
    host_u.start_cond();
    host_u.send_byte({dev, 1'b1}, a);
    ok = ok & a;
    got.delete();
    for (int i = 0; i < n; i++) begin
      host_u.get_byte(i < n - 1, b);
      got.push_back(b);
    end
    host_u.stop_cond();
  endtask

  task automatic write_bytes(input logic [15:0] wa);
    logic a;
    host_u.addr_phase(eid_dev_lo, wa, ok);
    foreach (wdat[i]) begin
      host_u.send_byte(wdat[i], a);
      ok = ok & a;
    end
    host_u.stop_cond();
  endtask

  // pins pass a filter, so give them time before the next frame
  task automatic settle();
    repeat (10) @(posedge clk);
    #1;
  endtask

  // ==========================================================================
  // hang guard, normal run is about 87300 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 95000) begin
      errors++;
      finish_test();
    end
  end

  // ==========================================================================
  // main sequence
  initial begin
    arst_n = 1'b0;
    addr_strap = 2'h0;
    wp = 1'b1;
    repeat (8) @(posedge clk);
    #1;
    check({13'h0, sda_out, sda_oe, write_busy}, 16'h0);
    arst_n = 1'b1;
    settle();
    $display("test reset done");
    // record fields at all strap settings and three bus rates
    foreach (rows[r]) begin
      addr_strap = rows[r].strap;
      host_u.half = rows[r].half;
      settle();
      read_bytes(eid_dev_lo | {5'h0, rows[r].strap}, rows[r].wa, 1);
      check({15'h0, ok}, 16'h1);
      check({8'h0, got[0]}, {8'h0, rows[r].exp});
    end
    host_u.half = 20;
    addr_strap = 2'h0;
    settle();
    $display("test table done");
    // foreign addresses: bit two low, other straps, wrong upper bits
    foreach (foreign[r]) begin
      host_u.addr_phase(foreign[r], 16'h0000, ok);
      host_u.stop_cond();
      check({15'h0, ok}, 16'h0);
    end
    $display("test refuse done");
    // whole signature in one sequential read
    read_bytes(eid_dev_lo, 16'h0000, 6);
    check({got[0], got[1]}, {eid_sig_0, eid_sig_1});
    check({got[2], got[3]}, {eid_sig_2, eid_sig_3});
    check({got[4], got[5]}, 16'h4131);
    // protected write leaves the blank byte alone
    wdat = '{8'h5a};
    write_bytes(16'h0300);
    check({15'h0, ok}, 16'h0);
    read_bytes(eid_dev_lo, 16'h0300, 1);
    check({8'h0, got[0]}, {8'h0, eid_blank});
    $display("test protect done");
    // 66 bytes from page offset 62: wrap, overwrite earliest, commit at stop
    wp = 1'b0;
    settle();
    wdat.delete();
    for (int i = 0; i < 66; i++) begin
      wdat.push_back(8'h10 + i[7:0]);
    end
    write_bytes(16'h027e);
    check({15'h0, ok}, 16'h1);
    check({15'h0, write_busy}, 16'h1);
    for (int i = 0; i < 400 && write_busy !== 1'b0; i++) begin
      @(posedge clk);
    end
    #1;
    check({15'h0, write_busy}, 16'h0);
    // page start holds bytes 2 onward; reading only the edges keeps the run short
    read_bytes(eid_dev_lo, 16'h0240, 4);
    for (int k = 0; k < 4; k++) begin
      check({8'h0, got[k]}, {8'h0, 8'h12 + k[7:0]});
    end
    // page end: offsets 62 and 63 hold the last two of the 66 bytes
    read_bytes(eid_dev_lo, 16'h027c, 5);
    for (int k = 0; k < 4; k++) begin
      check({8'h0, got[k]}, {8'h0, 8'h4e + k[7:0]});
    end
    check({8'h0, got[4]}, {8'h0, eid_blank});
    $display("test page done");
    // reset in mid run drops all outputs
    arst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check({13'h0, sda_out, sda_oe, write_busy}, 16'h0);
    arst_n = 1'b1;
    settle();
    // bus works again and the record survived the reset
    read_bytes(eid_dev_lo, 16'h0000, 1);
    check({7'h0, ok, got[0]}, {7'h0, 1'b1, eid_sig_0});
    $display("test midreset done");
    finish_test();
  end
endmodule // expansion_id_eeprom_tb
